// file: src/cuf_defs.svh
`ifndef CUF_DEFS_SVH
`define CUF_DEFS_SVH

// register indices, byte address is four times the index
`define CUF_IDX_PAGE      8'hAB
`define CUF_IDX_STATUS    8'hAD
`define CUF_IDX_EVENT     8'hAE
`define CUF_IDX_EVCLR     8'hAF

// word index taken from the byte address
`define CUF_ADDR_HI       9
`define CUF_ADDR_LO       2

// reset values
`define CUF_STATUS_RST    8'h80
`define CUF_EVENT_RST     8'h00
`define CUF_ENABLE_RST    8'h00

// flag positions, status and event registers share positions 7 and 0..5
`define CUF_B_TXBUF       7
`define CUF_B_RESV        6
`define CUF_B_CARD        6
`define CUF_B_CURR        5
`define CUF_B_VOLT        4
`define CUF_B_WAIT        3
`define CUF_B_TXC         2
`define CUF_B_RXC         1
`define CUF_B_PAR         0
`define CUF_B_PAGE        0

// writable bits of the enable register, reserved bit kept at zero
`define CUF_EN_MASK       8'hBF

// parity detections before the flag, receive and transmit
`define CUF_RX_PE_LIMIT   3'h4
`define CUF_TX_PE_LIMIT   3'h5

`endif

// file: src/cuf_pkg.sv
`default_nettype none

package cuf_pkg;

    // data phase of the bus slave
    typedef enum logic [1:0] {
        CUF_DPH_IDLE,
        CUF_DPH_WR,
        CUF_DPH_RD
    } cuf_dph_t;

    // one flag register
    typedef logic [7:0] cuf_flags_t;

endpackage : cuf_pkg

`default_nettype wire

// file: src/cuf_par_if.sv
`timescale 1ns/1ps
`default_nettype none

interface cuf_par_if;
    logic err_pulse;   // parity error seen on a character
    logic char_done;   // character ended without error
    logic rx_mode;     // 1 receive, 0 transmit
    logic rep_en;      // character repetition on
    logic flag_pulse;  // parity flag to be raised
    logic line_err;    // signal error on the card line

    modport core (output err_pulse, char_done, rx_mode, rep_en, input flag_pulse, line_err);
    modport rep  (input err_pulse, char_done, rx_mode, rep_en, output flag_pulse, line_err);
endinterface : cuf_par_if

`default_nettype wire

// file: src/cuf_parity_rep.sv
`timescale 1ns/1ps
`default_nettype none
`include "cuf_defs.svh"

module cuf_parity_rep #(
    parameter logic [2:0] RX_LIMIT = `CUF_RX_PE_LIMIT,
    parameter logic [2:0] TX_LIMIT = `CUF_TX_PE_LIMIT
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // repetition handshake
    cuf_par_if.rep    par
);

    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    logic       flag_q;
    logic       flag_d;
    logic       lerr_q;
    logic       lerr_d;

    // count repeated detections of one character
    always_comb
    begin
        logic [2:0] nxt;
        logic [2:0] lim;
        nxt    = cnt_q + 3'h1;
        lim    = par.rx_mode ? RX_LIMIT : TX_LIMIT;
        cnt_d  = cnt_q;
        flag_d = 1'b0;
        lerr_d = 1'b0;
        if (par.err_pulse)
        begin
            if (!par.rep_en || nxt >= lim)
            begin
                flag_d = 1'b1;   // see RULE12
                cnt_d  = 3'h0;
            end
            else
            begin
                cnt_d  = nxt;
                lerr_d = par.rx_mode;   // see RULE12
            end
        end
        else if (par.char_done)
        begin
            cnt_d = 3'h0;
        end
    end

    // register the counter and pulses
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q  <= 3'h0;
            flag_q <= 1'b0;
            lerr_q <= 1'b0;
        end
        else
        begin
            cnt_q  <= cnt_d;
            flag_q <= flag_d;
            lerr_q <= lerr_d;
        end
    end

    assign par.flag_pulse = flag_q;
    assign par.line_err   = lerr_q;

endmodule : cuf_parity_rep

`default_nettype wire

// file: src/cuf_top.sv
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "cuf_defs.svh"

// Behaviour
// RULE1 - status at 0xAD, events at 0xAE, both only while page select is 0
// RULE2 - status resets to 0x80, only transmit buffer empty set
// RULE3 - current overflow status follows the card overcurrent, cleared by hardware
// RULE4 - received character status set when a character is received
// RULE5 - received character status cleared when the data buffer is read
// RULE6 - transmit buffer event set when buffer moves into the shift register
// RULE7 - voltage error event set when card supply leaves its range
// RULE8 - receive event set when reception completes
// RULE9 - event register is read only, writes change nothing
// RULE10 - reading the event register returns flags then clears them
// RULE11 - event flags reset to zero, reserved bit 6 reads zero
// RULE12 - receive repetition: three line errors, parity flag on fourth detection
// RULE13 - each event reaches the interrupt only while its enable bit is set
// RULE14 - card present status follows card detection
// RULE15 - transmit complete and parity status stay set until software clears
module cuf_top (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rstn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // card uart events
    input  wire logic        tx_load_pulse,
    input  wire logic        tx_buf_wr_pulse,
    input  wire logic        tx_done_pulse,
    input  wire logic        rx_done_pulse,
    input  wire logic        data_buf_rd_pulse,
    input  wire logic        wt_timeout_pulse,
    input  wire logic        wt_reload_pulse,
    input  wire logic        parity_err_pulse,
    input  wire logic        char_ok_pulse,
    input  wire logic        rx_mode,
    input  wire logic        rep_en,
    // card supply and contacts
    input  wire logic        card_detect,
    input  wire logic        overcurrent,
    input  wire logic        volt_in_range,
    // outputs to the uart and cpu
    output logic             line_err_req,
    output logic             irq
);

    logic                  rst_meta_q;
    logic                  rst_n_q;
    cuf_pkg::cuf_dph_t     dph_q;
    cuf_pkg::cuf_dph_t     dph_d;
    logic [7:0]            idx_q;
    logic [7:0]            idx_d;
    logic                  hready_q;
    logic                  hready_d;
    logic [31:0]           hrdata_q;
    logic [31:0]           hrdata_d;
    logic                  page_q;
    logic                  page_d;
    cuf_pkg::cuf_flags_t   stat_q;
    cuf_pkg::cuf_flags_t   stat_d;
    cuf_pkg::cuf_flags_t   id_q;
    cuf_pkg::cuf_flags_t   id_d;
    cuf_pkg::cuf_flags_t   en_q;
    cuf_pkg::cuf_flags_t   en_d;
    cuf_pkg::cuf_flags_t   id_set;
    cuf_pkg::cuf_flags_t   id_clr;
    logic                  irq_q;
    logic                  irq_d;
    logic [7:0]            rd_val;
    logic [7:0]            wdat;
    logic                  accept;
    logic                  wr_now;
    logic                  rd_now;
    logic                  wr_stat;
    logic                  wr_en;
    logic                  wr_clr;
    logic                  wr_page;
    logic                  rd_id;

    cuf_par_if par_if ();

    // register selected by index and page
    function automatic logic reg_hit(input logic [7:0] idx, input logic [7:0] at,
                                     input logic page, input logic want);
        reg_hit = (idx == at) && (page == want);
    endfunction : reg_hit

    // reset release through two flops
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // parity repetition counter
    assign par_if.err_pulse = parity_err_pulse;
    assign par_if.char_done = char_ok_pulse;
    assign par_if.rx_mode   = rx_mode;
    assign par_if.rep_en    = rep_en;

    cuf_parity_rep u_rep (
        .mclk  (mclk),
        .rst_n (rst_n_q),
        .par   (par_if.rep)
    );

    // bus strobes, writes act in the data phase
    assign accept  = hsel && htrans[1] && hready;
    assign wr_now  = (dph_q == cuf_pkg::CUF_DPH_WR);
    assign rd_now  = (dph_q == cuf_pkg::CUF_DPH_RD);
    assign wdat    = hwdata[7:0];
    assign wr_stat = wr_now && reg_hit(idx_q, `CUF_IDX_STATUS, page_q, 1'b0);   // see RULE1
    assign wr_en   = wr_now && reg_hit(idx_q, `CUF_IDX_EVENT, page_q, 1'b1);
    assign wr_clr  = wr_now && (idx_q == `CUF_IDX_EVCLR);
    assign wr_page = wr_now && (idx_q == `CUF_IDX_PAGE);
    assign rd_id   = rd_now && reg_hit(idx_q, `CUF_IDX_EVENT, page_q, 1'b0);   // see RULE1

    // read data mux, unmapped reads zero
    always_comb
    begin
        rd_val = 8'h00;
        if (reg_hit(idx_q, `CUF_IDX_STATUS, page_q, 1'b0))   // see RULE1
            rd_val = stat_q;
        else if (reg_hit(idx_q, `CUF_IDX_EVENT, page_q, 1'b0))
            rd_val = id_q;
        else if (reg_hit(idx_q, `CUF_IDX_EVENT, page_q, 1'b1))
            rd_val = en_q;
        else if (idx_q == `CUF_IDX_PAGE)
            rd_val = {7'h00, page_q};
    end

    // bus phase next state, reads take one wait state
    always_comb
    begin
        dph_d    = dph_q;
        idx_d    = idx_q;
        hready_d = 1'b1;
        hrdata_d = hrdata_q;
        case (dph_q)
            cuf_pkg::CUF_DPH_IDLE,
            cuf_pkg::CUF_DPH_WR:
            begin
                dph_d = cuf_pkg::CUF_DPH_IDLE;
                if (accept)
                begin
                    idx_d    = haddr[`CUF_ADDR_HI:`CUF_ADDR_LO];
                    dph_d    = hwrite ? cuf_pkg::CUF_DPH_WR : cuf_pkg::CUF_DPH_RD;
                    hready_d = hwrite;
                end
            end
            cuf_pkg::CUF_DPH_RD:
            begin
                hrdata_d = {24'h000000, rd_val};   // see RULE10
                dph_d    = cuf_pkg::CUF_DPH_IDLE;
            end
            default:
            begin
                dph_d = cuf_pkg::CUF_DPH_IDLE;
            end
        endcase
    end

    // bus phase registers
    always_ff @(posedge mclk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            dph_q    <= cuf_pkg::CUF_DPH_IDLE;
            idx_q    <= 8'h00;
            hready_q <= 1'b1;
            hrdata_q <= 32'h00000000;
        end
        else
        begin
            dph_q    <= dph_d;
            idx_q    <= idx_d;
            hready_q <= hready_d;
            hrdata_q <= hrdata_d;
        end
    end

    // status flags, hardware set wins over any clear
    always_comb
    begin
        stat_d = stat_q;
        stat_d[`CUF_B_TXBUF] = tx_load_pulse | (stat_q[`CUF_B_TXBUF] & ~tx_buf_wr_pulse);
        stat_d[`CUF_B_CARD]  = card_detect;                                     // see RULE14
        stat_d[`CUF_B_CURR]  = overcurrent;                                     // see RULE3
        stat_d[`CUF_B_VOLT]  = volt_in_range;
        stat_d[`CUF_B_WAIT]  = wt_timeout_pulse | (stat_q[`CUF_B_WAIT] & ~wt_reload_pulse);
        stat_d[`CUF_B_TXC]   = tx_done_pulse
                             | (stat_q[`CUF_B_TXC] & ~(wr_stat & ~wdat[`CUF_B_TXC]));   // see RULE15
        stat_d[`CUF_B_RXC]   = rx_done_pulse
                             | (stat_q[`CUF_B_RXC] & ~data_buf_rd_pulse);       // see RULE4 see RULE5
        stat_d[`CUF_B_PAR]   = par_if.flag_pulse
                             | (stat_q[`CUF_B_PAR] & ~(wr_stat & ~wdat[`CUF_B_PAR]));   // see RULE15
    end

    // event flags, cleared by read or clear register, never by a write to them
    always_comb
    begin
        id_set = 8'h00;
        id_set[`CUF_B_TXBUF] = tx_load_pulse;                                   // see RULE6
        id_set[`CUF_B_CURR]  = overcurrent & ~stat_q[`CUF_B_CURR];
        id_set[`CUF_B_VOLT]  = ~volt_in_range & stat_q[`CUF_B_VOLT];            // see RULE7
        id_set[`CUF_B_WAIT]  = wt_timeout_pulse;
        id_set[`CUF_B_TXC]   = tx_done_pulse;
        id_set[`CUF_B_RXC]   = rx_done_pulse;                                   // see RULE8
        id_set[`CUF_B_PAR]   = par_if.flag_pulse;
        id_clr = (rd_id ? 8'hFF : 8'h00) | (wr_clr ? wdat : 8'h00);             // see RULE10 see RULE9
        id_d   = (id_q & ~id_clr) | id_set;
        en_d   = wr_en ? (wdat & `CUF_EN_MASK) : en_q;
        page_d = wr_page ? wdat[`CUF_B_PAGE] : page_q;
        irq_d  = |(id_d & en_d);                                                // see RULE13
    end

    // flag registers
    always_ff @(posedge mclk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            stat_q <= `CUF_STATUS_RST;   // see RULE2
            id_q   <= `CUF_EVENT_RST;    // see RULE11
            en_q   <= `CUF_ENABLE_RST;
            page_q <= 1'b0;
            irq_q  <= 1'b0;
        end
        else
        begin
            stat_q <= stat_d;
            id_q   <= id_d;
            en_q   <= en_d;
            page_q <= page_d;
            irq_q  <= irq_d;
        end
    end

    // outputs
    assign hrdata       = hrdata_q;
    assign hreadyout    = hready_q;
    assign hresp        = 1'b0;
    assign line_err_req = par_if.line_err;
    assign irq          = irq_q;

    // checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n_q);

    logic quiet_ev;
    assign quiet_ev = !(tx_load_pulse || tx_done_pulse || rx_done_pulse || wt_timeout_pulse
                      || par_if.flag_pulse || overcurrent || stat_q[`CUF_B_VOLT]);

    sequence s_rd_event;
        rd_id && quiet_ev;
    endsequence

    sequence s_event_gone;
        ##1 (hrdata_q[7:0] == $past(id_q)) && (id_q == 8'h00) && hready_q;
    endsequence

    property p_reset_vals;
        $rose(rst_n_q) |-> (stat_q == `CUF_STATUS_RST) && (id_q == `CUF_EVENT_RST);
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("flag reset value wrong"); // see RULE2 see RULE11

    property p_current;
        ##1 stat_q[`CUF_B_CURR] == $past(overcurrent);
    endproperty
    a_current: assert property (p_current) else $error("current flag wrong"); // see RULE3

    property p_rx_set;
        rx_done_pulse |=> stat_q[`CUF_B_RXC] && id_q[`CUF_B_RXC];
    endproperty
    a_rx_set: assert property (p_rx_set) else $error("receive flags not set"); // see RULE4 see RULE8

    property p_rx_clr;
        data_buf_rd_pulse && !rx_done_pulse |=> !stat_q[`CUF_B_RXC];
    endproperty
    a_rx_clr: assert property (p_rx_clr) else $error("receive status not cleared"); // see RULE5

    property p_txbuf;
        tx_load_pulse |=> id_q[`CUF_B_TXBUF] && stat_q[`CUF_B_TXBUF];
    endproperty
    a_txbuf: assert property (p_txbuf) else $error("transmit buffer flags not set"); // see RULE6

    property p_volt;
        $fell(volt_in_range) |=> id_q[`CUF_B_VOLT];
    endproperty
    a_volt: assert property (p_volt) else $error("voltage event missing"); // see RULE7

    property p_ro;
        wr_now && (idx_q == `CUF_IDX_EVENT) && !page_q && quiet_ev |=> id_q == $past(id_q);
    endproperty
    a_ro: assert property (p_ro) else $error("event register changed by write"); // see RULE9

    property p_rd_clear;
        s_rd_event |-> s_event_gone;
    endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("event read did not clear"); // see RULE10

    property p_rep;
        par_if.err_pulse && rep_en && rx_mode |=> par_if.line_err ^ par_if.flag_pulse;
    endproperty
    a_rep: assert property (p_rep) else $error("repetition step wrong"); // see RULE12

    property p_irq;
        irq_q == |(id_q & en_q);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not gated by enable"); // see RULE13

    property p_card;
        ##1 stat_q[`CUF_B_CARD] == $past(card_detect);
    endproperty
    a_card: assert property (p_card) else $error("card present flag wrong"); // see RULE14

    property p_hold;
        stat_q[`CUF_B_TXC] && !wr_stat |=> stat_q[`CUF_B_TXC];
    endproperty
    a_hold: assert property (p_hold) else $error("transmit complete dropped"); // see RULE15

endmodule : cuf_top

`default_nettype wire

// file: test/cuf_card_model.sv
`timescale 1ns/1ps
`default_nettype none

module cuf_card_model #(
    parameter int SLOW = 0
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rstn,
    // scenario commands
    input  wire logic insert,
    input  wire logic short_on,
    input  wire logic supply_bad,
    // contact levels seen by the device
    output logic      card_detect,
    output logic      overcurrent,
    output logic      volt_in_range,
    // error signalling driven onto the card line
    input  wire logic line_err_req,
    output var int    line_err_cnt
);
    logic [2:0] lvl_d;
    logic [2:0] lvl_q;
    int         cnt_d;
    int         cnt_q;

    // a short only loads the supply while a card is seated
    always_comb
    begin
        lvl_d = {insert, short_on & insert, insert & ~supply_bad};
        cnt_d = cnt_q + (line_err_req === 1'b1 ? 1 : 0);
    end

    // slow cards settle their contacts one cycle later
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            lvl_q <= 3'h0;
            cnt_q <= 0;
        end
        else
        begin
            lvl_q <= lvl_d;
            cnt_q <= cnt_d;
        end
    end

    assign {card_detect, overcurrent, volt_in_range} = (SLOW != 0) ? lvl_q : lvl_d;
    assign line_err_cnt = cnt_q;
endmodule : cuf_card_model

`default_nettype wire

// file: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "cuf_defs.svh"

module tb_top;
    typedef struct packed {logic [8:0] pls; logic [7:0] ev; logic [7:0] st;} cuf_row_t;

    logic        mclk;
    logic        rstn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [8:0]  pls;
    logic        rx_mode;
    logic        rep_en;
    logic        insert;
    logic        short_on;
    logic        supply_bad;
    logic        card_detect;
    logic        overcurrent;
    logic        volt_in_range;
    logic        line_err_req;
    logic        irq;
    logic [7:0]  rd;
    int          line_err_cnt;
    int          fails;
    int          num_checks;
    cuf_row_t    rows [6];

    // device under test, hready looped back from the one slave
    cuf_top dut_u (
        .mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .tx_load_pulse(pls[0]), .rx_done_pulse(pls[1]), .tx_done_pulse(pls[2]),
        .wt_timeout_pulse(pls[3]), .parity_err_pulse(pls[4]), .data_buf_rd_pulse(pls[5]),
        .tx_buf_wr_pulse(pls[6]), .wt_reload_pulse(pls[7]), .char_ok_pulse(pls[8]),
        .rx_mode(rx_mode), .rep_en(rep_en), .card_detect(card_detect), .overcurrent(overcurrent),
        .volt_in_range(volt_in_range), .line_err_req(line_err_req), .irq(irq)
    );

    // card on the contacts, answering slowly
    cuf_card_model #(.SLOW(1)) card_u (
        .mclk(mclk), .rstn(rstn), .insert(insert), .short_on(short_on), .supply_bad(supply_bad),
        .card_detect(card_detect), .overcurrent(overcurrent), .volt_in_range(volt_in_range),
        .line_err_req(line_err_req), .line_err_cnt(line_err_cnt)
    );

    // 125 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic conclude;
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick

    // waits for hready sampled high, bounded
    task automatic wait_ready;
        int n;
        n = 0;
        @(posedge mclk);
        while (hreadyout !== 1'b1 && n < 20)
        begin
            @(posedge mclk);
            n++;
        end
        if (n >= 20)
        begin
            fails++;
            conclude();
        end
    endtask : wait_ready

    // one single word transfer, address phase then data phase
    task automatic bus_xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr  <= {22'h0, idx, 2'h0};
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
        wait_ready();
        rd = hrdata[7:0];
    endtask : bus_xfer

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        bus_xfer(1'b0, idx, 8'h00);
        chk(rd, exp);
    endtask : rd_chk

    task automatic pulse(input logic [8:0] v);
        pls <= v;
        @(posedge mclk);
        pls <= 9'h000;
    endtask : pulse

    // main sequence
    initial
    begin
        rstn       = 1'b0;
        hsel       = 1'b0;
        haddr      = 32'h0;
        htrans     = 2'h0;
        hwrite     = 1'b0;
        hwdata     = 32'h0;
        pls        = 9'h000;
        rx_mode    = 1'b0;
        rep_en     = 1'b0;
        insert     = 1'b0;
        short_on   = 1'b0;
        supply_bad = 1'b0;
        fails      = 0;
        num_checks = 0;
        rows = '{'{9'h001, 8'h80, 8'hD0}, '{9'h002, 8'h02, 8'hD2}, '{9'h004, 8'h04, 8'hD6},
                 '{9'h008, 8'h08, 8'hDE}, '{9'h010, 8'h01, 8'hDF}, '{9'h005, 8'h84, 8'hDF}};
        tick(4);
        rstn <= 1'b1;
        tick(3);
        rd_chk(`CUF_IDX_STATUS, 8'h80);
        rd_chk(`CUF_IDX_EVENT, 8'h00);
        insert <= 1'b1;
        tick(4);
        rd_chk(`CUF_IDX_STATUS, 8'hD0);
        // ordinary events, one row each
        foreach (rows[i])
        begin
            pulse(rows[i].pls);
            tick(1);
            rd_chk(`CUF_IDX_EVENT, rows[i].ev);
            rd_chk(`CUF_IDX_EVENT, 8'h00);
            rd_chk(`CUF_IDX_STATUS, rows[i].st);
        end
        // buffer read, tx write and reload clear their status bits
        pulse(9'h0E0);
        tick(1);
        rd_chk(`CUF_IDX_STATUS, 8'h55);
        bus_xfer(1'b1, `CUF_IDX_STATUS, 8'h01);
        rd_chk(`CUF_IDX_STATUS, 8'h51);
        bus_xfer(1'b1, `CUF_IDX_STATUS, 8'h00);
        rd_chk(`CUF_IDX_STATUS, 8'h50);
        // card supply faults and removal
        short_on <= 1'b1;
        tick(4);
        rd_chk(`CUF_IDX_STATUS, 8'h70);
        short_on <= 1'b0;
        tick(4);
        rd_chk(`CUF_IDX_STATUS, 8'h50);
        supply_bad <= 1'b1;
        tick(4);
        rd_chk(`CUF_IDX_EVENT, 8'h30);
        rd_chk(`CUF_IDX_STATUS, 8'h40);
        insert <= 1'b0;
        tick(4);
        rd_chk(`CUF_IDX_STATUS, 8'h00);
        // writes to the event register are ignored
        bus_xfer(1'b1, `CUF_IDX_EVENT, 8'hFF);
        rd_chk(`CUF_IDX_EVENT, 8'h00);
        chk({7'h0, hresp}, 8'h00);
        rd_chk(8'h10, 8'h00);
        // page 1 exposes the enable register and hides the status
        bus_xfer(1'b1, `CUF_IDX_PAGE, 8'h01);
        bus_xfer(1'b1, `CUF_IDX_EVENT, 8'hFF);
        rd_chk(`CUF_IDX_EVENT, 8'hBF);
        rd_chk(`CUF_IDX_STATUS, 8'h00);
        bus_xfer(1'b1, `CUF_IDX_EVENT, 8'h02);
        bus_xfer(1'b1, `CUF_IDX_PAGE, 8'h00);
        // interrupt masked, raised, cleared
        pulse(9'h004);
        tick(3);
        chk({7'h0, irq}, 8'h00);
        pulse(9'h002);
        tick(3);
        chk({7'h0, irq}, 8'h01);
        bus_xfer(1'b1, `CUF_IDX_EVCLR, 8'h02);
        tick(2);
        chk({7'h0, irq}, 8'h00);
        rd_chk(`CUF_IDX_EVENT, 8'h04);
        // receive repetition, count restarted by a good character
        rep_en  <= 1'b1;
        rx_mode <= 1'b1;
        tick(1);
        repeat (2)
        begin
            pulse(9'h010);
            tick(2);
        end
        pulse(9'h100);
        tick(2);
        repeat (3)
        begin
            pulse(9'h010);
            tick(2);
        end
        rd_chk(`CUF_IDX_EVENT, 8'h00);
        chk(line_err_cnt[7:0], 8'h05);
        pulse(9'h010);
        tick(2);
        rd_chk(`CUF_IDX_EVENT, 8'h01);
        chk(line_err_cnt[7:0], 8'h05);
        // transmit repetition, flag on the fifth detection, no line error
        rx_mode <= 1'b0;
        repeat (4)
        begin
            pulse(9'h010);
            tick(2);
        end
        rd_chk(`CUF_IDX_EVENT, 8'h00);
        pulse(9'h010);
        tick(2);
        rd_chk(`CUF_IDX_EVENT, 8'h01);
        chk(line_err_cnt[7:0], 8'h05);
        // reset in mid-run with an enabled event pending
        pulse(9'h002);
        tick(1);
        chk({7'h0, irq}, 8'h01);
        rstn <= 1'b0;
        tick(2);
        rstn <= 1'b1;
        tick(3);
        chk({7'h0, irq}, 8'h00);
        rd_chk(`CUF_IDX_STATUS, 8'h80);
        rd_chk(`CUF_IDX_EVENT, 8'h00);
        conclude();
    end
endmodule : tb_top

`default_nettype wire
